// ==== core/gfr_pkg.sv ====
// Shared constants for the global fault syndrome and translation result bank
package gfr_pkg;

	// ****************************************************************
	// Register bus geometry
	// ****************************************************************
	localparam int          ADDR_W          = 8;
	localparam int          DATA_W          = 32;

	// ****************************************************************
	// Register byte offsets, one aligned word each
	// ****************************************************************
	localparam logic [7:0]  OFF_SYN_ONE     = 8'h00; // Own bank syndrome one
	localparam logic [7:0]  OFF_SYN_TWO     = 8'h04; // Own bank syndrome two
	localparam logic [7:0]  OFF_RES_LO      = 8'h08; // Own bank result, bits 31:0
	localparam logic [7:0]  OFF_RES_HI      = 8'h0C; // Own bank result, bits 63:32
	localparam logic [7:0]  OFF_ALIAS_ONE   = 8'h10; // Secure alias of non-secure syndrome one
	localparam logic [7:0]  OFF_ALIAS_TWO   = 8'h14; // Secure alias of non-secure syndrome two
	localparam logic [7:0]  OFF_ALIAS_LO    = 8'h18; // Secure alias of non-secure result low
	localparam logic [7:0]  OFF_ALIAS_HI    = 8'h1C; // Secure alias of non-secure result high
	localparam logic [7:0]  OFF_IRQ_STATUS  = 8'h20; // Sticky events, read only
	localparam logic [7:0]  OFF_IRQ_ENABLE  = 8'h24; // Event enables, read/write
	localparam logic [7:0]  OFF_IRQ_CLEAR   = 8'h28; // Write one to clear, write only

	// ****************************************************************
	// Banks and reset values
	// ****************************************************************
	localparam logic        BANK_NS         = 1'b0;
	localparam logic        BANK_S          = 1'b1;
	localparam logic [31:0] RST_WORD        = 32'h0000_0000;
	localparam logic [63:0] RST_RESULT      = 64'h0000_0000_0000_0000;

	// ****************************************************************
	// Event bits of the interrupt registers
	// ****************************************************************
	localparam int          EVT_W           = 4;
	localparam int          EVT_FAULT_NS    = 0; // Non-secure fault captured
	localparam int          EVT_FAULT_S     = 1; // Secure fault captured
	localparam int          EVT_XLAT_OK     = 2; // Translation finished successfully
	localparam int          EVT_XLAT_ABORT  = 3; // Translation aborted

	// ****************************************************************
	// Result field positions
	// ****************************************************************
	localparam int          RES_FAULT       = 0;
	localparam int          RES_SUPER       = 1;
	localparam int          RES_SH_SHORT    = 7;
	localparam int          RES_IMP_SHORT   = 8;
	localparam int          RES_NS          = 9;
	localparam int          RES_NOS         = 10;
	localparam int          RES_IMP_LONG    = 10;
	localparam int          RES_PA_LSB      = 12;
	localparam int          RES_PA_MSB      = 47;
	localparam int          RES_MEMORY_ATTRIBUTES_LSB   = 56;

endpackage

// ==== core/gfr_bank.sv ====
// Global fault syndrome and global translation result register bank
//
// Our own choices: the address map and the strobed register port.
`timescale 1ns/100ps
module gfr_bank
	import gfr_pkg::*;
#(
	parameter int           SID_BITS        = 16,   // Implemented stream identifier bits
	parameter int           PA_BITS         = 48,   // Larger of input and output widths
	parameter bit           OS_DISTINCT     = 1'b1  // Outer shareable is distinguished
)
(
	input  wire logic               sys_clk,        // System clock, 250 MHz
	input  wire logic               nrst,           // Asynchronous reset, active low
	input  wire logic [ADDR_W-1:0]  reg_addr,       // Register byte address
	input  wire logic [DATA_W-1:0]  reg_wdata,      // Write data
	input  wire logic               reg_wr,         // Write strobe
	input  wire logic               reg_rd,         // Read strobe
	input  wire logic               reg_secure,     // Requester is secure
	output logic      [DATA_W-1:0]  reg_rdata,      // Read data, cycle after strobe
	input  wire logic               fault_valid,    // Global fault capture pulse
	input  wire logic               fault_secure,   // Faulting transaction is secure
	input  wire logic [15:0]        fault_sid,      // Stream identifier of fault
	input  wire logic               xlat_done,      // Translation operation finished
	input  wire logic               xlat_secure,    // Operation issued by secure side
	input  wire logic               xlat_abort,     // Operation aborted
	input  wire logic               xlat_long,      // Long-descriptor scheme in use
	input  wire logic [47:12]       xlat_pa,        // Physical address result
	input  wire logic               xlat_super,     // Short result is a supersection
	input  wire logic               xlat_nos,       // Not outer shareable
	input  wire logic               xlat_ns,        // Entry nonsecure attribute
	input  wire logic               xlat_impl,      // Implementation bit
	input  wire logic [1:0]         xlat_sh,        // Shareability, bit 0 used in short
	input  wire logic [2:0]         xlat_inner,     // Inner memory type
	input  wire logic [1:0]         xlat_outer,     // Outer memory type
	input  wire logic [7:0]         xlat_memory_attributes,     // Attribute byte for long scheme
	output logic                    irq             // Level interrupt
);

	// ****************************************************************
	// State
	// ****************************************************************
	typedef struct packed
	{
		logic [1:0][SID_BITS-1:0]   sid;            // Syndrome one per bank
		logic [1:0][31:0]           syn_two;        // Syndrome two per bank
		logic [1:0][63:0]           res;            // Translation result per bank
		logic [EVT_W-1:0]           irq_stat;       // Sticky events
		logic [EVT_W-1:0]           irq_en;         // Event enables
		logic [DATA_W-1:0]          rdata;          // Registered read data
		logic                       irq;            // Registered interrupt
	} gfr_state_t;

	gfr_state_t                     state_reg;
	gfr_state_t                     state_next;

	// Unimplemented address bits inside 47:12 read zero and drop writes
	localparam logic [63:0]         PA_HOLE     = (64'h1 << 48) - (64'h1 << PA_BITS);
	localparam logic [63:0]         RES_WMASK   = ~PA_HOLE;

	// ****************************************************************
	// Access decode
	// ****************************************************************
	logic                           own_bank;
	logic                           alias_hit;
	logic [EVT_W-1:0]               evt;
	logic [63:0]                    res_new;

	// Plain offsets follow the requester; aliases reach the non-secure copy
	assign own_bank  = reg_secure ? BANK_S : BANK_NS;
	assign alias_hit = reg_secure;

	// ****************************************************************
	// Result layouts
	// ****************************************************************
	// Short-descriptor success word
	function automatic logic [63:0] short_word(input logic bank_s, input logic [63:0] old);
		logic [63:0] w;
		w = 64'h0;
		if (xlat_super)
		begin
			w[31:24] = xlat_pa[31:24];
			w[23:16] = xlat_pa[39:32];
		end
		else
		begin
			w[31:12] = xlat_pa[31:12];
		end
		w[RES_NOS]       = OS_DISTINCT ? xlat_nos : old[RES_NOS];
		w[RES_NS]        = bank_s & xlat_ns;
		w[RES_IMP_SHORT] = xlat_impl;
		w[RES_SH_SHORT]  = xlat_sh[0];
		w[6:4]           = xlat_inner;
		w[3:2]           = xlat_outer;
		w[RES_SUPER]     = xlat_super;
		w[RES_FAULT]     = 1'b0;
		return w;
	endfunction

	// Long-descriptor success word
	function automatic logic [63:0] long_word(input logic bank_s);
		logic [63:0] w;
		w = 64'h0;
		w[63:RES_MEMORY_ATTRIBUTES_LSB]       = xlat_memory_attributes;
		w[RES_PA_MSB:RES_PA_LSB]  = xlat_pa;
		w                         = w & RES_WMASK;
		w[RES_IMP_LONG]           = xlat_impl;
		w[RES_NS]                 = bank_s & xlat_ns;
		w[8:7]                    = xlat_sh;
		w[RES_FAULT]              = 1'b0;
		return w;
	endfunction

	// Pick the layout for the bank being written; fault layout sets bit 0 only
	always_comb
	begin
		if (xlat_abort)
			res_new = 64'h1 << RES_FAULT;
		else if (xlat_long)
			res_new = long_word(xlat_secure);
		else
			res_new = short_word(xlat_secure, state_reg.res[xlat_secure]);
	end

	// Events raised this cycle
	assign evt[EVT_FAULT_NS]   = fault_valid & ~fault_secure;
	assign evt[EVT_FAULT_S]    = fault_valid & fault_secure;
	assign evt[EVT_XLAT_OK]    = xlat_done & ~xlat_abort;
	assign evt[EVT_XLAT_ABORT] = xlat_done & xlat_abort;

	// ****************************************************************
	// Next state
	// ****************************************************************
	// Software writes first, hardware updates afterwards so they win a collision
	always_comb
	begin
		state_next       = state_reg;
		state_next.rdata = RST_WORD;

		if (reg_wr)
		begin
			unique case (reg_addr)
				OFF_SYN_ONE:    state_next.sid[own_bank] = reg_wdata[SID_BITS-1:0];
				OFF_SYN_TWO:    state_next.syn_two[own_bank] = reg_wdata;
				OFF_RES_LO:     state_next.res[own_bank][31:0] =
					reg_wdata & RES_WMASK[31:0];
				OFF_RES_HI:     state_next.res[own_bank][63:32] =
					reg_wdata & RES_WMASK[63:32];
				OFF_ALIAS_ONE:  if (alias_hit)
					state_next.sid[BANK_NS] = reg_wdata[SID_BITS-1:0];
				OFF_ALIAS_TWO:  if (alias_hit)
					state_next.syn_two[BANK_NS] = reg_wdata;
				OFF_ALIAS_LO:   if (alias_hit)
					state_next.res[BANK_NS][31:0] = reg_wdata & RES_WMASK[31:0];
				OFF_ALIAS_HI:   if (alias_hit)
					state_next.res[BANK_NS][63:32] = reg_wdata & RES_WMASK[63:32];
				OFF_IRQ_ENABLE: state_next.irq_en = reg_wdata[EVT_W-1:0];
				OFF_IRQ_CLEAR:  state_next.irq_stat = state_reg.irq_stat & ~reg_wdata[EVT_W-1:0];
				default:        ;
			endcase
		end

		if (reg_rd)
		begin
			unique case (reg_addr)
				OFF_SYN_ONE:    state_next.rdata = 32'(state_reg.sid[own_bank]);
				OFF_SYN_TWO:    state_next.rdata = state_reg.syn_two[own_bank];
				OFF_RES_LO:     state_next.rdata = state_reg.res[own_bank][31:0];
				OFF_RES_HI:     state_next.rdata = state_reg.res[own_bank][63:32];
				OFF_ALIAS_ONE:  if (alias_hit)
					state_next.rdata = 32'(state_reg.sid[BANK_NS]);
				OFF_ALIAS_TWO:  if (alias_hit)
					state_next.rdata = state_reg.syn_two[BANK_NS];
				OFF_ALIAS_LO:   if (alias_hit)
					state_next.rdata = state_reg.res[BANK_NS][31:0];
				OFF_ALIAS_HI:   if (alias_hit)
					state_next.rdata = state_reg.res[BANK_NS][63:32];
				OFF_IRQ_STATUS: state_next.rdata = 32'(state_reg.irq_stat);
				OFF_IRQ_ENABLE: state_next.rdata = 32'(state_reg.irq_en);
				default:        state_next.rdata = RST_WORD;  // Unmapped reads zero
			endcase
		end

		// Fault capture into the bank of the faulting transaction
		if (fault_valid)
			state_next.sid[fault_secure] = fault_sid[SID_BITS-1:0];

		// Hardware moves the result only when an operation finishes
		if (xlat_done)
			state_next.res[xlat_secure] = res_new;

		// Set beats clear in the same cycle
		state_next.irq_stat = state_next.irq_stat | evt;
		state_next.irq      = |(state_next.irq_stat & state_next.irq_en);
	end

	// ****************************************************************
	// Registers
	// ****************************************************************
	// Reset to zero even where software must treat contents as unknown
	always_ff @(posedge sys_clk or negedge nrst)
	begin
		if (!nrst)
		begin
			state_reg          <= '0;
		end
		else
		begin
			state_reg          <= state_next;
		end
	end

	assign reg_rdata = state_reg.rdata;
	assign irq       = state_reg.irq;

	// ****************************************************************
	// Checks
	// ****************************************************************
	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (!nrst);

	sequence done_short_s;
		xlat_done && !xlat_abort && !xlat_long;
	endsequence

	sequence done_long_s;
		xlat_done && !xlat_abort && xlat_long;
	endsequence

	sequence sid_read_s;
		reg_rd && reg_addr == OFF_SYN_ONE;
	endsequence

	// Short success without supersection keeps the address as it is
	sequence short_flat_s;
		xlat_done && !xlat_abort && !xlat_long && !xlat_super;
	endsequence

	// Non-secure requester aiming at the secure alias window
	sequence alias_wr_ns_s;
		reg_wr && !reg_secure && reg_addr >= OFF_ALIAS_ONE && reg_addr <= OFF_ALIAS_HI;
	endsequence

	sid_capture_a: assert property (
		fault_valid |=> state_reg.sid[$past(fault_secure)] == $past(fault_sid[SID_BITS-1:0]))
		else $error("stream identifier not captured");

	sid_read_a: assert property (
		fault_valid ##1 (sid_read_s and (reg_secure == $past(fault_secure) && !fault_valid))
		|=> reg_rdata == 32'($past(fault_sid[SID_BITS-1:0], 2)))
		else $error("syndrome one read does not show captured identifier");

	syn_two_rw_a: assert property (
		(reg_wr && reg_addr == OFF_SYN_TWO) ##1 (reg_rd && reg_addr == OFF_SYN_TWO
		&& reg_secure == $past(reg_secure)) |=> reg_rdata == $past(reg_wdata, 2))
		else $error("syndrome two write not read back");

	res_bank_a: assert property (
		(xlat_done && !xlat_secure && !(reg_wr && reg_secure))
		|=> $stable(state_reg.res[BANK_S]))
		else $error("non-secure operation touched secure result");

	short_upper_a: assert property (
		done_short_s |=> state_reg.res[$past(xlat_secure)][63:32] == 32'h0000_0000)
		else $error("short layout upper word not zero");

	short_attr_a: assert property (
		done_short_s |=> state_reg.res[$past(xlat_secure)][7:1] ==
		{$past(xlat_sh[0]), $past(xlat_inner), $past(xlat_outer), $past(xlat_super)})
		else $error("short layout attribute bits wrong");

	short_nos_a: assert property (
		(done_short_s and OS_DISTINCT)
		|=> state_reg.res[$past(xlat_secure)][RES_NOS] == $past(xlat_nos))
		else $error("not outer shareable bit wrong");

	ns_bit_a: assert property (
		(xlat_done && !xlat_abort && !xlat_secure) |=> state_reg.res[BANK_NS][RES_NS] == 1'b0)
		else $error("non-secure copy shows nonsecure attribute");

	super_map_a: assert property (
		(done_short_s and xlat_super) |=> state_reg.res[$past(xlat_secure)][31:12] ==
		{$past(xlat_pa[31:24]), $past(xlat_pa[39:32]), 4'h0})
		else $error("supersection address mapping wrong");

	ok_fault_a: assert property (
		(xlat_done && !xlat_abort) |=> state_reg.res[$past(xlat_secure)][RES_FAULT] == 1'b0)
		else $error("successful result has fault bit set");

	long_memory_attributes_a: assert property (
		done_long_s |=> state_reg.res[$past(xlat_secure)][63:56] == $past(xlat_memory_attributes))
		else $error("memory attribute byte wrong");

	long_pa_a: assert property (
		done_long_s |=> (state_reg.res[$past(xlat_secure)] & PA_HOLE) == 64'h0
		&& state_reg.res[$past(xlat_secure)][RES_PA_MSB:RES_PA_LSB] ==
		($past(xlat_pa) & RES_WMASK[RES_PA_MSB:RES_PA_LSB]))
		else $error("long layout address wrong");

	abort_a: assert property (
		(xlat_done && xlat_abort) |=> state_reg.res[$past(xlat_secure)] == 64'h1)
		else $error("aborted operation not marked");

	hold_a: assert property (
		(!xlat_done && !reg_wr) |=> $stable(state_reg.res))
		else $error("result changed without cause");

	irq_level_a: assert property (
		(state_reg.irq_stat & state_reg.irq_en) != '0 |-> irq)
		else $error("interrupt low while enabled event pending");

	sticky_set_a: assert property (
		evt != '0 |=> (state_reg.irq_stat & $past(evt)) == $past(evt))
		else $error("event lost against clear");

	short_pa_a: assert property (
		short_flat_s |=> state_reg.res[$past(xlat_secure)][31:12] == $past(xlat_pa[31:12]))
		else $error("short layout address bits wrong");

	short_inner_a: assert property (
		done_short_s |=> state_reg.res[$past(xlat_secure)][6:4] == $past(xlat_inner))
		else $error("inner memory type not carried");

	short_outer_a: assert property (
		done_short_s |=> state_reg.res[$past(xlat_secure)][3:2] == $past(xlat_outer))
		else $error("outer memory type not carried");

	// Long layout keeps its reserved fields clear so software sees zero
	long_layout_a: assert property (
		done_long_s |=> state_reg.res[$past(xlat_secure)][8:1] == {$past(xlat_sh), 6'h00}
		&& state_reg.res[$past(xlat_secure)][55:48] == 8'h00)
		else $error("long layout shareability or reserved bits wrong");

	alias_refuse_a: assert property (
		(alias_wr_ns_s and (!fault_valid && !xlat_done))
		|=> $stable(state_reg.res[BANK_NS]) && $stable(state_reg.syn_two[BANK_NS])
		&& $stable(state_reg.sid[BANK_NS]))
		else $error("non-secure write reached the alias window");

	sid_width_a: assert property (
		sid_read_s |=> reg_rdata[DATA_W-1:SID_BITS] == '0)
		else $error("unimplemented identifier bits not zero");

	hole_read_a: assert property (
		(reg_rd && reg_addr == OFF_RES_HI) |=> (reg_rdata & PA_HOLE[63:32]) == 32'h0000_0000)
		else $error("unimplemented address bits not zero");

	// Hardware never touches syndrome two, only software does
	syn_two_hw_a: assert property (
		!reg_wr |=> $stable(state_reg.syn_two))
		else $error("syndrome two changed without a write");

	rdata_idle_a: assert property (
		!reg_rd |=> reg_rdata == RST_WORD)
		else $error("read data stands beyond its cycle");

endmodule

// ==== bench/testbench.sv ====
// Self-checking bench for the global fault syndrome and translation result bank
`timescale 1ns/100ps
module testbench;
	import gfr_pkg::*;

	// ****************************************************************
	// Signals and bench state
	// ****************************************************************
	localparam int          TB_SID = 12;   // Narrow ids so missing bits are seen
	localparam int          TB_PA  = 40;   // Narrow address so 47:40 must read zero
	logic                   sys_clk = 1'b0;
	logic                   nrst, reg_wr, reg_rd, reg_secure, irq;
	logic [ADDR_W-1:0]      reg_addr;
	logic [DATA_W-1:0]      reg_wdata, reg_rdata, d, hi;
	logic                   fault_valid, fault_secure, xlat_done, xlat_secure, xlat_abort;
	logic                   xlat_long, xlat_super, xlat_nos, xlat_ns, xlat_impl;
	logic [15:0]            fault_sid;
	logic [47:12]           xlat_pa;
	logic [1:0]             xlat_sh, xlat_outer;
	logic [2:0]             xlat_inner;
	logic [7:0]             xlat_memory_attributes;
	logic [63:0]            model [2];     // Expected result per bank
	logic [31:0]            rng = 32'h0001_8602;
	logic [3:0]             stat;
	int                     errors = 0, cmp_count = 0, cyc = 0, cnt = 0;

	gfr_bank #(.SID_BITS(TB_SID), .PA_BITS(TB_PA), .OS_DISTINCT(1'b1)) DUT (
		.sys_clk(sys_clk), .nrst(nrst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
		.reg_wr(reg_wr), .reg_rd(reg_rd), .reg_secure(reg_secure), .reg_rdata(reg_rdata),
		.fault_valid(fault_valid), .fault_secure(fault_secure), .fault_sid(fault_sid),
		.xlat_done(xlat_done), .xlat_secure(xlat_secure), .xlat_abort(xlat_abort),
		.xlat_long(xlat_long), .xlat_pa(xlat_pa), .xlat_super(xlat_super),
		.xlat_nos(xlat_nos), .xlat_ns(xlat_ns), .xlat_impl(xlat_impl), .xlat_sh(xlat_sh),
		.xlat_inner(xlat_inner), .xlat_outer(xlat_outer), .xlat_memory_attributes(xlat_memory_attributes),
		.irq(irq));

	// ****************************************************************
	// Clock, watchdog and helpers
	// ****************************************************************
	always #2 sys_clk = ~sys_clk;

	// Any hang ends the run as a failure
	always @(posedge sys_clk)
	begin
		cyc++;
		if (cyc > 60000)
		begin
			errors++;
			close_out();
		end
	end

	function automatic logic [31:0] xs();
		rng = rng ^ (rng << 13);
		rng = rng ^ (rng >> 17);
		rng = rng ^ (rng << 5);
		return rng;
	endfunction

	// Expected result word from the inputs held after a finished translation
	function automatic logic [63:0] exp_res();
		logic [63:0] r;
		r = 64'h0;
		if (xlat_abort)
			return 64'h1;
		r[9] = xlat_secure & xlat_ns;
		if (xlat_long)
		begin
			r[63:56] = xlat_memory_attributes;
			r[TB_PA-1:12] = xlat_pa[TB_PA-1:12];
			r[10] = xlat_impl;
			r[8:7] = xlat_sh;
		end
		else
		begin
			r[31:12] = xlat_super ? {xlat_pa[31:24], xlat_pa[39:32], 4'h0} : xlat_pa[31:12];
			r[10] = xlat_nos;
			r[8] = xlat_impl;
			r[7] = xlat_sh[0];
			r[6:4] = xlat_inner;
			r[3:2] = xlat_outer;
			r[1] = xlat_super;
		end
		return r;
	endfunction

	task automatic chk(input logic [63:0] seen, input logic [63:0] exp);
		cmp_count++;
		if (seen !== exp)
		begin
			errors++;
			$display("[FAIL] %0t ns seen %h expected %h", $time, seen, exp);
		end
	endtask

	task automatic close_out();
		$display("Comparisons %0d, mismatches %0d", cmp_count, errors);
		if (errors == 0 && cmp_count > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask

	// ****************************************************************
	// Bus and event drivers
	// ****************************************************************
	// One-cycle write strobe
	task automatic wr(input logic [7:0] a, input logic [31:0] w, input logic s);
		@(posedge sys_clk);
		reg_addr <= a;
		reg_wdata <= w;
		reg_secure <= s;
		reg_wr <= 1'b1;
		@(posedge sys_clk);
		reg_wr <= 1'b0;
	endtask

	// Read data is sampled mid-cycle, the only cycle it stands
	task automatic rd(input logic [7:0] a, input logic s, output logic [31:0] q);
		@(posedge sys_clk);
		reg_addr <= a;
		reg_secure <= s;
		reg_rd <= 1'b1;
		@(posedge sys_clk);
		reg_rd <= 1'b0;
		@(negedge sys_clk);
		q = reg_rdata;
	endtask

	// Write then read back in the very next cycle, no gap
	task automatic wr_rd(input logic [7:0] a, input logic [31:0] w, input logic s,
		output logic [31:0] q);
		@(posedge sys_clk);
		reg_addr <= a;
		reg_wdata <= w;
		reg_secure <= s;
		reg_wr <= 1'b1;
		@(posedge sys_clk);
		reg_wr <= 1'b0;
		reg_rd <= 1'b1;
		@(posedge sys_clk);
		reg_rd <= 1'b0;
		@(negedge sys_clk);
		q = reg_rdata;
	endtask

	// Fault pulse, then syndrome one read from the same bank right after
	task automatic fault(input logic s, input logic [15:0] sid, output logic [31:0] q);
		@(posedge sys_clk);
		fault_secure <= s;
		fault_sid <= sid;
		fault_valid <= 1'b1;
		@(posedge sys_clk);
		fault_valid <= 1'b0;
		reg_addr <= OFF_SYN_ONE;
		reg_secure <= s;
		reg_rd <= 1'b1;
		@(posedge sys_clk);
		reg_rd <= 1'b0;
		@(negedge sys_clk);
		q = reg_rdata;
	endtask

	// Inner and outer codes walk a counter so every encoding is reached
	task automatic xlat(input logic s, input logic ab, input logic lg);
		logic [63:0] p;
		logic [31:0] w;
		p = {xs(), xs()};
		w = xs();
		@(posedge sys_clk);
		xlat_secure <= s;
		xlat_abort <= ab;
		xlat_long <= lg;
		xlat_pa <= (cnt % 5 == 0) ? '1 : p[35:0];
		{xlat_super, xlat_nos, xlat_ns, xlat_impl} <= w[3:0];
		xlat_sh <= w[5:4];
		xlat_memory_attributes <= w[15:8];
		xlat_inner <= cnt[2:0];
		xlat_outer <= cnt[4:3];
		xlat_done <= 1'b1;
		@(posedge sys_clk);
		xlat_done <= 1'b0;
		model[s] = exp_res();
		stat[ab ? EVT_XLAT_ABORT : EVT_XLAT_OK] = 1'b1;
		cnt++;
	endtask

	task automatic chk_bank(input logic s);
		rd(OFF_RES_LO, s, d);
		rd(OFF_RES_HI, s, hi);
		chk({hi, d}, model[s]);
	endtask

	// ****************************************************************
	// Main sequence
	// ****************************************************************
	initial
	begin
		{nrst, reg_wr, reg_rd, reg_secure, fault_valid, fault_secure, xlat_done} = '0;
		{xlat_secure, xlat_abort, xlat_long, xlat_super, xlat_nos, xlat_ns, xlat_impl} = '0;
		{reg_addr, reg_wdata, fault_sid, xlat_pa, xlat_sh, xlat_outer} = '0;
		{xlat_inner, xlat_memory_attributes} = '0;
		model[0] = RST_RESULT;
		model[1] = RST_RESULT;
		stat = 4'h0;
		repeat (10) @(posedge sys_clk);
		nrst <= 1'b1;
		// Reset contents of both banks
		for (int s = 0; s < 2; s++)
		begin
			rd(OFF_SYN_TWO, s[0], d);
			chk(d, RST_WORD);
			chk_bank(s[0]);
		end
		chk(irq, 1'b0);
		// Syndrome two is read/write per bank, secure alias sees non-secure copy
		wr_rd(OFF_SYN_TWO, 32'hA5A5_0F0F, 1'b0, d);
		chk(d, 32'hA5A5_0F0F);
		wr_rd(OFF_SYN_TWO, 32'h5A5A_F0F0, 1'b1, d);
		chk(d, 32'h5A5A_F0F0);
		rd(OFF_SYN_TWO, 1'b0, d);
		chk(d, 32'hA5A5_0F0F);
		rd(OFF_SYN_TWO, 1'b1, d);
		chk(d, 32'h5A5A_F0F0);
		rd(OFF_ALIAS_TWO, 1'b1, d);
		chk(d, 32'hA5A5_0F0F);
		rd(OFF_ALIAS_TWO, 1'b0, d);
		chk(d, 32'h0);
		@(negedge sys_clk);
		chk(reg_rdata, 32'h0);
		// Faults land in the bank of the faulting transaction, narrow id
		for (int i = 0; i < 6; i++)
		begin
			d = (i == 0) ? 32'hFFFF : xs();
			fault(i[0], d[15:0], hi);
			stat[i[0] ? EVT_FAULT_S : EVT_FAULT_NS] = 1'b1;
			chk(hi, {20'h0, d[TB_SID-1:0]});
		end
		// Random translations with interrupts masked
		for (int i = 0; i < 48; i++)
		begin
			d = xs();
			xlat(d[0], d[3:2] == 2'b11, d[1]);
			chk_bank(1'b0);
			chk_bank(1'b1);
			chk(irq, 1'b0);
			if (i == 20)
			begin
				hi = xs();
				wr(OFF_RES_LO, hi, 1'b1);
				model[1][31:0] = hi;
				fault(1'b1, 16'h0123, hi);
				chk(hi, 32'h0000_0123);
				chk_bank(1'b1);
			end
		end
		// Secure alias writes the non-secure copy; a non-secure try is dropped
		wr(OFF_ALIAS_LO, 32'h1234_5678, 1'b1);
		wr(OFF_ALIAS_LO, 32'hDEAD_0000, 1'b0);
		model[0][31:0] = 32'h1234_5678;
		chk_bank(1'b0);
		rd(OFF_ALIAS_LO, 1'b1, d);
		chk(d, model[0][31:0]);
		rd(OFF_ALIAS_HI, 1'b0, d);
		chk(d, 32'h0);
		rd(OFF_IRQ_STATUS, 1'b0, d);
		chk(d, {28'h0, stat});
		// Interrupt: clear, enable aborts only, success stays low, abort raises, clear
		wr(OFF_IRQ_CLEAR, 32'hF, 1'b0);
		wr(OFF_IRQ_ENABLE, 32'h1 << EVT_XLAT_ABORT, 1'b0);
		rd(OFF_IRQ_STATUS, 1'b0, d);
		chk(d, 32'h0);
		xlat(1'b0, 1'b0, 1'b0);
		repeat (2) @(negedge sys_clk);
		chk(irq, 1'b0);
		xlat(1'b1, 1'b1, 1'b1);
		repeat (2) @(negedge sys_clk);
		chk(irq, 1'b1);
		chk_bank(1'b1);
		wr(OFF_IRQ_CLEAR, 32'h1 << EVT_XLAT_ABORT, 1'b0);
		repeat (2) @(negedge sys_clk);
		chk(irq, 1'b0);
		rd(OFF_IRQ_STATUS, 1'b0, d);
		chk(d, 32'h1 << EVT_XLAT_OK);
		rd(8'hF0, 1'b1, d);
		chk(d, 32'h0);
		close_out();
	end
endmodule
